// ==== hw/uhp_pkg.sv ====
package uhp_pkg;
	// Timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned RST_MIN_NS = 40;
	localparam int unsigned RST_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned TMO_BITS = 40;
	// FIFOs
	localparam int unsigned FIFO_DEPTH = 64;
	localparam int unsigned FIFO_AW = 6;
	// Register indices, byte address = 4 * index
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_MASK = 3'h1;
	localparam logic [2:0] IDX_FCTL = 3'h2;
	localparam logic [2:0] IDX_LCTL = 3'h3;
	localparam logic [2:0] IDX_MCTL = 3'h4;
	localparam logic [2:0] IDX_ISTAT = 3'h5;
	localparam logic [2:0] IDX_TXDIV = 3'h6;
	localparam logic [2:0] IDX_RXDIV = 3'h7;
	// fifo_control fields
	localparam int unsigned FC_EN = 0;
	localparam int unsigned FC_RXRST = 1;
	localparam int unsigned FC_TXRST = 2;
	localparam int unsigned FC_RXTRIG = 8;
	localparam int unsigned FC_TXTRIG = 16;
	localparam int unsigned FC_RXCNT = 8;
	localparam int unsigned FC_TXCNT = 16;
	// line_control fields
	localparam int unsigned LC_NINE = 0;
	localparam int unsigned LC_SWFC = 1;
	localparam int unsigned LC_HWFC = 2;
	localparam int unsigned LC_MARK = 3;
	localparam int unsigned LC_XON = 8;
	localparam int unsigned LC_XOFF = 16;
	// modem_control fields
	localparam int unsigned MC_RTS = 0;
	localparam int unsigned MC_RS485 = 3;
	localparam int unsigned MC_ANYXON = 5;
	localparam int unsigned MC_PRESC = 7;
	// Interrupt status bits
	localparam int unsigned IS_TX = 0;
	localparam int unsigned IS_RX = 1;
	localparam int unsigned IS_TMO = 2;
	localparam int unsigned IS_OVR = 3;
	localparam int unsigned IS_W = 4;
	// Reset values
	localparam logic [31:0] FCTL_RST = 32'h0000_0000;
	localparam logic [31:0] LCTL_RST = 32'h0013_1100;
	localparam logic [7:0] MCTL_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'h0;
	// Oversampling codes
	localparam logic [1:0] OS_16 = 2'h0;
	localparam logic [1:0] OS_8 = 2'h1;
	localparam logic [1:0] OS_4 = 2'h2;

	typedef struct packed {
		logic [1:0] os;
		logic [3:0] frac;
		logic [15:0] div;
	} uhp_brg_t;

	localparam uhp_brg_t BRG_RST = 22'h000001;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_START = 3'h1,
		S_DATA = 3'h3,
		S_NINTH = 3'h2,
		S_STOP = 3'h6
	} uhp_ser_t;
endpackage

// ==== hw/uhp_uart.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Host port carries 32 data bits, three address bits select eight registers.
// - Register accesses finish without waiting on any baud or reference timing.
// - Bus style pin picks reset polarity and interrupt output form.
// - Reset held over 40 ns returns registers and serial outputs to defaults.
// - Separate 64-byte transmit and receive FIFOs sit between host and shifters.
// - Reference clock passes a divide-by-1-or-4 prescaler before the baud generators.
// - modem_control bit 7 selects divide by 4, clear selects divide by 1.
// - With modem_control bit 5 set, any received character other than Xoff releases a software halt.
// - FIFOs off: interrupt asserts while tx_holding is empty, either polarity.
// - FIFOs on: interrupt asserts while transmit FIFO is at or below trigger.
// - FIFOs off: interrupt asserts while a byte waits in rx_holding.
// - FIFOs on: interrupt asserts above receive trigger or on receive timeout.
// - 4X oversampling is supported beside 8X and 16X.
// - Nine-bit multidrop, RS-485 direction, separate baud rates, fractional divisor.
// - Automatic RTS/CTS and Xon/Xoff flow control without host help.
// - One clock, SYS_CLK, drives both the baud generators and the host port.
module uhp_uart (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Mode and reset pins
	input wire logic BUS_STYLE,
	input wire logic UART_RESET,
	// Interrupts
	output logic HOST_INTERRUPT,
	output logic IRQ_N_O,
	output logic IRQ_N_OE,
	// Serial pins
	input wire logic RXD,
	input wire logic CTS_N,
	output logic TXD,
	output logic RTS_N,
	output logic DIR
);
	import uhp_pkg::*;

	function automatic logic [4:0] os_len(input logic [1:0] os);
		os_len = (os == OS_4) ? 5'h04 : (os == OS_8) ? 5'h08 : 5'h10;
	endfunction

	// Fractional divisor: fixed point in sixteenths, one sample tick per wrap
	function automatic logic [20:0] brg_step(input logic [19:0] acc, input uhp_brg_t b);
		logic [20:0] sum;
		logic [20:0] d;
		sum = {1'b0, acc} + 21'h000010;
		d = ({b.div, b.frac} < 20'h00010) ? 21'h000010 : {1'b0, b.div, b.frac};
		brg_step = (sum >= d) ? {1'b1, 20'(sum - d)} : {1'b0, sum[19:0]};
	endfunction

	// Pin synchronisers
	logic [1:0] style_sy_ff, urst_sy_ff, rxd_sy_ff, cts_sy_ff;
	always_ff @(posedge SYS_CLK) begin
		style_sy_ff <= {style_sy_ff[0], BUS_STYLE};
		urst_sy_ff <= {urst_sy_ff[0], UART_RESET};
		rxd_sy_ff <= {rxd_sy_ff[0], RXD};
		cts_sy_ff <= {cts_sy_ff[0], CTS_N};
	end
	wire style = style_sy_ff[1];

	// Pin reset: polarity follows bus style, must hold RST_CYC cycles
	logic [1:0] prst_cnt_ff;
	wire prst_act = style ? urst_sy_ff[1] : ~urst_sy_ff[1];
	wire prst_done = prst_cnt_ff >= 2'(RST_CYC - 1);
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN || !prst_act)
			prst_cnt_ff <= 2'h0;
		else if (!prst_done)
			prst_cnt_ff <= prst_cnt_ff + 2'h1;
	end
	wire rst = !RESETN || (prst_act && prst_done);

	// APB decode, zero wait state
	wire [2:0] idx = PADDR[4:2];
	wire mapped = (PADDR[7:5] == 3'h0) && (PADDR[1:0] == 2'h0);
	wire setup = PSEL && !PENABLE;
	wire acc_ok = PSEL && PENABLE && mapped;
	wire wr = acc_ok && PWRITE;
	wire rd = acc_ok && !PWRITE;
	assign PREADY = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// Registers
	logic [31:0] fctl_ff, lctl_ff;
	logic [7:0] mctl_ff;
	logic [IS_W-1:0] mask_ff, stat_ff;
	uhp_brg_t txdiv_ff, rxdiv_ff;
	wire fen = fctl_ff[FC_EN];
	wire [5:0] rx_trig = fctl_ff[FC_RXTRIG +: 6];
	wire [5:0] tx_trig = fctl_ff[FC_TXTRIG +: 6];
	wire [7:0] xon_ch = lctl_ff[LC_XON +: 8];
	wire [7:0] xoff_ch = lctl_ff[LC_XOFF +: 8];
	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			fctl_ff <= FCTL_RST;
			lctl_ff <= LCTL_RST;
			mctl_ff <= MCTL_RST;
			mask_ff <= MASK_RST;
			txdiv_ff <= BRG_RST;
			rxdiv_ff <= BRG_RST;
		end else if (wr) begin
			if (idx == IDX_FCTL)
				fctl_ff <= PWDATA & 32'h003f_3f01;
			if (idx == IDX_LCTL)
				lctl_ff <= PWDATA & 32'h00ff_ff0f;
			if (idx == IDX_MCTL)
				mctl_ff <= PWDATA[7:0];
			if (idx == IDX_MASK)
				mask_ff <= PWDATA[IS_W-1:0];
			if (idx == IDX_TXDIV)
				txdiv_ff <= PWDATA[21:0];
			if (idx == IDX_RXDIV)
				rxdiv_ff <= PWDATA[21:0];
		end
	end
	wire fifo_rx_clr = wr && idx == IDX_FCTL && PWDATA[FC_RXRST];
	wire fifo_tx_clr = wr && idx == IDX_FCTL && PWDATA[FC_TXRST];

	// FIFOs; with FIFOs off each acts as a one-byte holding register
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
	logic [FIFO_AW:0] tx_cnt_ff, rx_cnt_ff;
	wire [FIFO_AW:0] cap = fen ? 7'(FIFO_DEPTH) : 7'h01;
	wire tx_full = tx_cnt_ff >= cap;
	wire rx_full = rx_cnt_ff >= cap;
	wire tx_push = wr && idx == IDX_DATA && !tx_full;
	wire rx_pop = rd && idx == IDX_DATA && rx_cnt_ff != 7'h00;
	logic tx_pop, rx_push;
	logic [7:0] rx_byte_ff;
	always_ff @(posedge SYS_CLK) begin
		if (tx_push)
			tx_mem[tx_wp_ff] <= PWDATA[7:0];
		if (rx_push)
			rx_mem[rx_wp_ff] <= rx_byte_ff;
	end
	always_ff @(posedge SYS_CLK) begin
		if (rst || fifo_tx_clr) begin
			tx_wp_ff <= '0;
			tx_rp_ff <= '0;
			tx_cnt_ff <= '0;
		end else begin
			tx_wp_ff <= tx_wp_ff + FIFO_AW'(tx_push);
			tx_rp_ff <= tx_rp_ff + FIFO_AW'(tx_pop);
			tx_cnt_ff <= tx_cnt_ff + 7'(tx_push) - 7'(tx_pop);
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (rst || fifo_rx_clr) begin
			rx_wp_ff <= '0;
			rx_rp_ff <= '0;
			rx_cnt_ff <= '0;
		end else begin
			rx_wp_ff <= rx_wp_ff + FIFO_AW'(rx_push);
			rx_rp_ff <= rx_rp_ff + FIFO_AW'(rx_pop);
			rx_cnt_ff <= rx_cnt_ff + 7'(rx_push) - 7'(rx_pop);
		end
	end

	// Prescaler and baud generators; host port never waits on them
	logic [1:0] pre_ff;
	logic [19:0] tx_acc_ff, rx_acc_ff;
	wire pre_tick = mctl_ff[MC_PRESC] ? (pre_ff == 2'h3) : 1'b1;
	wire [20:0] tx_step = brg_step(tx_acc_ff, txdiv_ff);
	wire [20:0] rx_step = brg_step(rx_acc_ff, rxdiv_ff);
	wire tx_tick = pre_tick && tx_step[20];
	wire rx_tick = pre_tick && rx_step[20];
	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			pre_ff <= 2'h0;
			tx_acc_ff <= '0;
			rx_acc_ff <= '0;
		end else begin
			pre_ff <= pre_ff + 2'h1;
			if (pre_tick) begin
				tx_acc_ff <= tx_step[19:0];
				rx_acc_ff <= rx_step[19:0];
			end
		end
	end

	// Transmitter
	uhp_ser_t tx_st_ff;
	logic [4:0] tx_os_ff;
	logic [2:0] tx_bit_ff;
	logic [7:0] tx_sh_ff;
	logic txd_ff, halt_ff;
	wire [4:0] tx_osl = os_len(txdiv_ff.os);
	wire tx_bdone = tx_tick && tx_os_ff == tx_osl - 5'h01;
	wire tx_hold = (lctl_ff[LC_HWFC] && cts_sy_ff[1]) || (lctl_ff[LC_SWFC] && halt_ff);
	assign tx_pop = tx_tick && tx_st_ff == S_IDLE && tx_cnt_ff != 7'h00 && !tx_hold;
	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			tx_st_ff <= S_IDLE;
			tx_os_ff <= 5'h00;
			tx_bit_ff <= 3'h0;
			tx_sh_ff <= 8'h00;
			txd_ff <= 1'b1;
		end else if (tx_pop) begin
			tx_st_ff <= S_START;
			tx_os_ff <= 5'h00;
			tx_sh_ff <= tx_mem[tx_rp_ff];
			txd_ff <= 1'b0;
		end else if (tx_tick && tx_st_ff != S_IDLE) begin
			tx_os_ff <= tx_bdone ? 5'h00 : tx_os_ff + 5'h01;
			if (tx_bdone) begin
				case (tx_st_ff)
					S_START: begin
						tx_st_ff <= S_DATA;
						tx_bit_ff <= 3'h0;
						txd_ff <= tx_sh_ff[0];
					end
					S_DATA: begin
						tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
						tx_bit_ff <= tx_bit_ff + 3'h1;
						if (tx_bit_ff == 3'h7) begin
							tx_st_ff <= lctl_ff[LC_NINE] ? S_NINTH : S_STOP;
							txd_ff <= lctl_ff[LC_NINE] ? lctl_ff[LC_MARK] : 1'b1;
						end else
							txd_ff <= tx_sh_ff[1];
					end
					S_NINTH: begin
						tx_st_ff <= S_STOP;
						txd_ff <= 1'b1;
					end
					default: begin
						tx_st_ff <= S_IDLE;
						txd_ff <= 1'b1;
					end
				endcase
			end
		end
	end
	assign TXD = txd_ff;
	assign DIR = mctl_ff[MC_RS485] && tx_st_ff != S_IDLE;

	// Receiver
	uhp_ser_t rx_st_ff;
	logic [4:0] rx_os_ff;
	logic [2:0] rx_bit_ff;
	logic [7:0] rx_sh_ff;
	logic rx_got_ff, ovr_ev;
	wire rxd = rxd_sy_ff[1];
	wire [4:0] rx_osl = os_len(rxdiv_ff.os);
	wire rx_mid = rx_os_ff == {1'b0, rx_osl[4:1]} - 5'h01;
	wire rx_end = rx_os_ff == rx_osl - 5'h01;
	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			rx_st_ff <= S_IDLE;
			rx_os_ff <= 5'h00;
			rx_bit_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_got_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
		end else begin
			rx_got_ff <= 1'b0;
			if (rx_tick) begin
				rx_os_ff <= rx_os_ff + 5'h01;
				case (rx_st_ff)
					S_IDLE: begin
						rx_os_ff <= 5'h00;
						if (!rxd)
							rx_st_ff <= S_START;
					end
					S_START: if (rx_mid) begin
						rx_os_ff <= 5'h00;
						rx_bit_ff <= 3'h0;
						rx_st_ff <= rxd ? S_IDLE : S_DATA;
					end
					S_DATA: if (rx_end) begin
						rx_os_ff <= 5'h00;
						rx_sh_ff <= {rxd, rx_sh_ff[7:1]};
						rx_bit_ff <= rx_bit_ff + 3'h1;
						if (rx_bit_ff == 3'h7)
							rx_st_ff <= lctl_ff[LC_NINE] ? S_NINTH : S_STOP;
					end
					S_NINTH: if (rx_end) begin
						rx_os_ff <= 5'h00;
						rx_st_ff <= S_STOP;
					end
					S_STOP: if (rx_end) begin
						rx_st_ff <= S_IDLE;
						rx_got_ff <= rxd;
						rx_byte_ff <= rx_sh_ff;
					end
					default: rx_st_ff <= S_IDLE;
				endcase
			end
		end
	end
	assign rx_push = rx_got_ff && !rx_full;
	assign ovr_ev = rx_got_ff && rx_full;

	// Software flow control from received characters
	always_ff @(posedge SYS_CLK) begin
		if (rst || !lctl_ff[LC_SWFC])
			halt_ff <= 1'b0;
		else if (rx_got_ff) begin
			if (rx_byte_ff == xoff_ch)
				halt_ff <= 1'b1;
			else if (rx_byte_ff == xon_ch || mctl_ff[MC_ANYXON])
				halt_ff <= 1'b0;
		end
	end
	assign RTS_N = lctl_ff[LC_HWFC] ? (rx_cnt_ff > {1'b0, rx_trig}) : !mctl_ff[MC_RTS];

	// Receive timeout: TMO_BITS bit times with data waiting and no traffic
	logic [10:0] tmo_ff;
	wire [10:0] tmo_lim = 11'(rx_osl) * 11'(TMO_BITS);
	wire tmo = tmo_ff >= tmo_lim;
	always_ff @(posedge SYS_CLK) begin
		if (rst || rx_push || rx_pop || rx_cnt_ff == 7'h00 || rx_st_ff != S_IDLE)
			tmo_ff <= 11'h000;
		else if (rx_tick && !tmo)
			tmo_ff <= tmo_ff + 11'h001;
	end

	// Interrupt conditions per FIFO mode
	wire tx_cond = fen ? (tx_cnt_ff <= {1'b0, tx_trig}) : (tx_cnt_ff == 7'h00);
	wire rx_cond = fen ? (rx_cnt_ff > {1'b0, rx_trig}) : (rx_cnt_ff != 7'h00);
	wire [IS_W-1:0] ev = {ovr_ev, fen && tmo, rx_cond, tx_cond};

	// Read data captured in setup; only reported bits are cleared on access
	logic [31:0] prdata_ff;
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		case (idx)
			IDX_DATA: rmux = {24'h000000, rx_mem[rx_rp_ff]};
			IDX_MASK: rmux = {28'h0000000, mask_ff};
			IDX_FCTL: rmux = {9'h000, tx_cnt_ff, 1'b0, rx_cnt_ff, 7'h00, fen};
			IDX_LCTL: rmux = lctl_ff;
			IDX_MCTL: rmux = {24'h000000, mctl_ff};
			IDX_ISTAT: rmux = {28'h0000000, stat_ff};
			IDX_TXDIV: rmux = {10'h000, txdiv_ff};
			default: rmux = {10'h000, rxdiv_ff};
		endcase
	end
	always_ff @(posedge SYS_CLK) begin
		if (rst)
			prdata_ff <= 32'h0000_0000;
		else if (setup)
			prdata_ff <= (!PWRITE && mapped) ? rmux : 32'h0000_0000;
	end
	assign PRDATA = prdata_ff;

	wire [IS_W-1:0] st_clr = (rd && idx == IDX_ISTAT) ? prdata_ff[IS_W-1:0] : '0;
	always_ff @(posedge SYS_CLK) begin
		if (rst)
			stat_ff <= '0;
		else
			stat_ff <= (stat_ff & ~st_clr) | ev;
	end

	wire irq = |(stat_ff & mask_ff);
	assign HOST_INTERRUPT = style && irq;
	assign IRQ_N_O = 1'b0;
	assign IRQ_N_OE = !style && irq;
endmodule // uhp_uart

// ==== tb/uhp_uart_properties.sv ====
`timescale 1ns/1ps
module uhp_uart_properties (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Pins
	input wire logic BUS_STYLE,
	input wire logic HOST_INTERRUPT,
	input wire logic IRQ_N_O,
	input wire logic IRQ_N_OE,
	input wire logic TXD
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	property p_ready;
		(PSEL && !PENABLE) ##1 PENABLE |-> PREADY;
	endproperty
	a_ready: assert property (p_ready) else $error("access phase without ready");
	property p_err_scope;
		PSLVERR |-> PSEL && PENABLE;
	endproperty
	a_err_scope: assert property (p_err_scope) else $error("error outside access");
	property p_err_unmap;
		PSEL && PENABLE && (PADDR[7:5] != 3'h0 || PADDR[1:0] != 2'h0) |-> PSLVERR && PRDATA == 0;
	endproperty
	a_err_unmap: assert property (p_err_unmap) else $error("bad address accepted");
	property p_wr_quiet;
		PSEL && PENABLE && PWRITE |-> PRDATA == 32'h0;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("read data driven on write");
	property p_byte;
		PSEL && PENABLE && !PWRITE && PADDR == 8'h00 |-> PRDATA[31:8] == 24'h0;
	endproperty
	a_byte: assert property (p_byte) else $error("data wider than a byte");
	property p_rst;
		$rose(RESETN) |-> TXD && PRDATA == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not at defaults");
	property p_od;
		IRQ_N_OE |-> !IRQ_N_O && !HOST_INTERRUPT;
	endproperty
	a_od: assert property (p_od) else $error("open drain line misdriven");
	property p_style1;
		BUS_STYLE [*4] |-> !IRQ_N_OE;
	endproperty
	a_style1: assert property (p_style1) else $error("low irq in high style");
	property p_style0;
		!BUS_STYLE [*4] |-> !HOST_INTERRUPT;
	endproperty
	a_style0: assert property (p_style0) else $error("high irq in low style");
endmodule // uhp_uart_properties

// ==== tb/uhp_peer.sv ====
`timescale 1ns/1ps
module uhp_peer (
	// Clock
	input wire logic clk,
	// Serial lines
	input wire logic txd,
	output logic rxd
);
	// Line idles at mark level
	initial rxd = 1'b1;
	task automatic send_byte(input logic [7:0] b, input int bit_cyc);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= frame[i];
			repeat (bit_cyc) @(posedge clk);
		end
	endtask
	// Samples mid-bit so prescaler phase slack is tolerated
	task automatic get_byte(input int bit_cyc, output logic [7:0] b);
		int n;
		n = 0;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		repeat (bit_cyc / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc) @(posedge clk);
			b[i] = txd;
		end
	endtask
endmodule // uhp_peer

// ==== tb/test_uhp_uart.sv ====
`timescale 1ns/1ps
module test_uhp_uart;
	import uhp_pkg::*;
	logic sys_clk, resetn, psel, penable, pwrite, bus_style, uart_reset, cts_n;
	logic [7:0] paddr, got;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, host_int, irq_o, irq_oe, txd, rxd, err, rts_n, dir;
	wire irq_n = irq_oe ? irq_o : 1'b1;
	int failures = 0;
	int comparisons = 0;
	int cyc = 0;

	uhp_uart i_uhp_uart (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .BUS_STYLE(bus_style), .UART_RESET(uart_reset),
		.HOST_INTERRUPT(host_int), .IRQ_N_O(irq_o), .IRQ_N_OE(irq_oe), .RXD(rxd),
		.CTS_N(cts_n), .TXD(txd), .RTS_N(rts_n), .DIR(dir));
	uhp_peer i_uhp_peer (.clk(sys_clk), .txd(txd), .rxd(rxd));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish();
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [7:0] ad(input logic [2:0] idx);
		return {3'h0, idx, 2'h0};
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 50) begin
			failures++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic t_reset();
		apb(0, ad(IDX_MASK), 0);
		chk("mask", 32'h0, rd);
		apb(0, ad(IDX_LCTL), 0);
		chk("line_control", LCTL_RST, rd);
		apb(0, ad(IDX_MCTL), 0);
		chk("modem_control", 32'h0, rd);
		apb(0, ad(IDX_FCTL), 0);
		chk("fifo_control", FCTL_RST, rd);
		chk("rts_n", 32'h1, 32'(rts_n));
	endtask

	task automatic t_unmapped();
		apb(0, 8'h20, 0);
		chk("slverr", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
		apb(1, 8'h06, 32'hff);
		chk("slverr", 32'h1, 32'(err));
	endtask

	task automatic t_tx(input logic [1:0] os, input logic presc, input logic [7:0] b);
		int bc;
		bc = (os == OS_4) ? 4 : (os == OS_8) ? 8 : 16;
		bc = presc ? bc * 4 : bc;
		apb(1, ad(IDX_TXDIV), {10'h0, os, 4'h0, 16'h1});
		apb(1, ad(IDX_MCTL), presc ? 32'h88 : 32'h08);
		fork
			i_uhp_peer.get_byte(bc, got);
			apb(1, ad(IDX_DATA), {24'h0, b});
		join
		chk("tx byte", {24'h0, b}, {24'h0, got});
		chk("dir", 32'h1, 32'(dir));
	endtask

	task automatic t_irq_tx();
		apb(1, ad(IDX_MASK), 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("host_interrupt", 32'h1, 32'(host_int));
		apb(1, ad(IDX_MASK), 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("host_interrupt", 32'h0, 32'(host_int));
	endtask

	task automatic t_rx();
		// Prescaler off so one bit is four clocks on both sides
		apb(1, ad(IDX_MCTL), 32'h0);
		apb(1, ad(IDX_RXDIV), {10'h0, OS_4, 4'h0, 16'h1});
		apb(1, ad(IDX_MASK), 32'h2);
		i_uhp_peer.send_byte(8'hc3, 4);
		repeat (8) @(posedge sys_clk);
		chk("host_interrupt", 32'h1, 32'(host_int));
		apb(0, ad(IDX_DATA), 0);
		chk("rx byte", 32'hc3, rd);
		apb(0, ad(IDX_ISTAT), 0);
		repeat (2) @(posedge sys_clk);
		chk("host_interrupt", 32'h0, 32'(host_int));
	endtask

	// CTS held off so the FIFO fills without draining
	task automatic t_fifo();
		cts_n <= 1'b1;
		apb(1, ad(IDX_LCTL), 32'h0013_1104);
		apb(1, ad(IDX_FCTL), 32'h0010_0001);
		for (int i = 0; i < 65; i++) begin
			apb(1, ad(IDX_DATA), 32'(i));
		end
		apb(0, ad(IDX_FCTL), 0);
		chk("tx count", 32'd64, 32'(rd[22:16]));
		chk("rts_n", 32'h0, 32'(rts_n));
		apb(0, ad(IDX_ISTAT), 0);
		apb(0, ad(IDX_ISTAT), 0);
		chk("tx status", 32'h0, 32'(rd[IS_TX]));
		apb(1, ad(IDX_FCTL), 32'h0010_0005);
		apb(0, ad(IDX_ISTAT), 0);
		chk("tx status", 32'h1, 32'(rd[IS_TX]));
		cts_n <= 1'b0;
		apb(1, ad(IDX_LCTL), LCTL_RST);
		apb(1, ad(IDX_FCTL), 32'h0);
	endtask

	task automatic t_style0();
		bus_style <= 1'b0;
		uart_reset <= 1'b1;
		repeat (6) @(posedge sys_clk);
		apb(1, ad(IDX_MASK), 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irq_n", 32'h0, 32'(irq_n));
		chk("host_interrupt", 32'h0, 32'(host_int));
		uart_reset <= 1'b0;
		repeat (6) @(posedge sys_clk);
		uart_reset <= 1'b1;
		repeat (6) @(posedge sys_clk);
		apb(0, ad(IDX_MASK), 0);
		chk("mask", 32'h0, rd);
		chk("irq_n", 32'h1, 32'(irq_n));
	endtask

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bus_style = 1'b1;
		uart_reset = 1'b0;
		cts_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset();
		t_unmapped();
		t_tx(OS_4, 1'b0, 8'h5a);
		t_tx(OS_8, 1'b0, 8'ha5);
		t_tx(OS_4, 1'b1, 8'h3c);
		t_irq_tx();
		t_rx();
		t_fifo();
		t_style0();
		tally_and_finish();
	end
endmodule // test_uhp_uart

bind uhp_uart uhp_uart_properties i_uhp_uart_properties (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_STYLE(BUS_STYLE), .HOST_INTERRUPT(HOST_INTERRUPT),
	.IRQ_N_O(IRQ_N_O), .IRQ_N_OE(IRQ_N_OE), .TXD(TXD));
